// *** verilog/fbmc_pkg.sv ***
// Overview of operation
// - flash is five blocks: two 8k below 4000h, three 16k up to FFFFh
// - boot rom enable maps the 2k boot rom over F800h to FFFFh
// - boot rom enable clear exposes the whole 64k flash to fetches
// - boot rom enable starts the internal pump when vpp is tied to vdd
// - voltage-valid rises once programming voltage is ready, about 5 us
// - reset sets boot rom enable on non-zero status byte or strap, else clears
// - flash idle bit plus cpu idle powers flash down; wake costs 3 us
// - at reset release a zero status byte starts execution at 0000h
// - non-zero status byte takes the 4-byte boot vector as reset vector
// - factory boot vector is 8000h status word and F800h program counter
// - a programming error forces the status byte non-zero
// - erasing status byte or boot vector erases both together
// - strapped boot acts like non-zero status byte and enables boot rom
// - flash is read and programmed per byte, 40 us per program
// - block erase clears one block, chip erase clears all flash
// - external select low fetches code from external memory up to 1 Mbyte
// - aux control resets to 1x00 0000b on boot, bit 6 is voltage-valid
package fbmc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 40000;
  localparam int VPP_READY_NS = 5000;
  localparam int WAKE_TIME_NS = 3000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPP_CYCLES = (VPP_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_FETCH_CYCLES = 3;
  localparam int INT_FETCH_CYCLES = 1;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_AUX = 5'h00;
  localparam logic [4:0] REG_CMD = 5'h04;
  localparam logic [4:0] REG_ADDR = 5'h08;
  localparam logic [4:0] REG_WDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int AUX_BOOT_BIT = 7;
  localparam int AUX_VALID_BIT = 6;
  localparam int AUX_FLASH_IDLE_REQUEST_BIT = 6;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_ERROR_BIT = 2;
  localparam int ST_VECTOR_BIT = 3;
  localparam int ST_RDATA_LSB = 8;
  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_BLOCK_ERASE = 3'h2;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_NV_ERASE = 3'h5;
  localparam logic [2:0] OP_NV_PROG = 3'h6;
  // ----------------------------------------------------------------
  // memory map and values
  // ----------------------------------------------------------------
  localparam logic [15:0] BOOT_ROM_BASE = 16'hF800;
  localparam logic [15:0] FLASH_FIRST = 16'h0000;
  localparam logic [15:0] FLASH_TOP = 16'hFFFF;
  localparam logic [15:0] SMALL_BLOCK_TOP = 16'h3FFF;
  localparam logic [15:0] SMALL_BLOCK_MASK = 16'h1FFF;
  localparam logic [15:0] LARGE_BLOCK_MASK = 16'h3FFF;
  localparam logic [15:0] NORMAL_RESET_PC = 16'h0000;
  localparam logic [15:0] NORMAL_RESET_PSW = 16'h0000;
  localparam logic [15:0] FACTORY_BOOT_STATUS_WORD = 16'h8000;
  localparam logic [15:0] FACTORY_BPC = 16'hF800;
  localparam logic [7:0] FACTORY_STATUS = 8'hFF;
  localparam logic [7:0] STATUS_ERROR_VALUE = 8'hFF;
  localparam logic [7:0] NV_ERASED = 8'h00;
  localparam logic [7:0] FLASH_ERASED = 8'hFF;
  localparam logic [2:0] NV_STATUS = 3'h0;
  localparam logic [2:0] NV_PSW_LO = 3'h1;
  localparam logic [2:0] NV_PSW_HI = 3'h2;
  localparam logic [2:0] NV_PC_LO = 3'h3;
  localparam logic [2:0] NV_PC_HI = 3'h4;
  localparam int NV_BYTES = 5;
  typedef enum logic [1:0] {
    FBMC_IDLE = 2'b00,
    FBMC_PROG = 2'b01,
    FBMC_ERASE = 2'b11
  } fbmc_state_t;
  typedef enum logic [1:0] {
    FBMC_SRC_FLASH = 2'b00,
    FBMC_SRC_ROM = 2'b01,
    FBMC_SRC_EXT = 2'b11
  } fbmc_src_t;
endpackage

// *** verilog/fbmc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbmc_top #(
  parameter int PROG_WAIT = fbmc_pkg::PROG_CYCLES,
  parameter int VPP_WAIT = fbmc_pkg::VPP_CYCLES,
  parameter int WAKE_WAIT = fbmc_pkg::WAKE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic FETCH_REQ,
  input wire logic [19:0] FETCH_ADDR,
  output logic FETCH_WAIT,
  output logic FETCH_VALID,
  output logic [7:0] FETCH_DATA,
  output logic [10:0] BOOT_ROM_ADDR,
  input wire logic [7:0] BOOT_ROM_DATA,
  output logic EXT_CODE_RD,
  output logic [19:0] EXT_CODE_ADDR,
  input wire logic [7:0] EXT_CODE_DATA,
  input wire logic EXTERNAL_CODE_SELECT,
  input wire logic PROGRAM_FETCH_STROBE_N,
  input wire logic ADDRESS_LATCH_STROBE,
  input wire logic VPP_TIED_TO_VDD,
  input wire logic VPP_EXTERNAL_OK,
  input wire logic CPU_IDLE,
  output logic BOOT_ROM_ENABLE,
  output logic PROG_VOLTAGE_VALID,
  output logic VPP_PUMP_ON,
  output logic FLASH_POWER_DOWN,
  output logic BOOT_VECTOR_USED,
  output logic [15:0] RESET_PC,
  output logic [15:0] RESET_PSW
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pin_raw;
  logic [12:0] sync1_reg;
  logic [12:0] sync2_reg;
  assign pin_raw = {EXT_CODE_DATA, VPP_EXTERNAL_OK, VPP_TIED_TO_VDD, ADDRESS_LATCH_STROBE,
                    PROGRAM_FETCH_STROBE_N, EXTERNAL_CODE_SELECT};
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK) begin
        sync1_reg[gi] <= pin_raw[gi];
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  endgenerate
  logic ext_sel_s, program_fetch_strobe_n_n_s, ale_s, vpp_tied_s, vpp_ext_s;
  logic [7:0] ext_data_s;
  assign ext_sel_s = sync2_reg[0];
  assign program_fetch_strobe_n_n_s = sync2_reg[1];
  assign ale_s = sync2_reg[2];
  assign vpp_tied_s = sync2_reg[3];
  assign vpp_ext_s = sync2_reg[4];
  assign ext_data_s = sync2_reg[12:5];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] flash_mem [0:65535];
  // factory-programmed non-volatile bytes: status, psw lo/hi, pc lo/hi
  logic [7:0] nv_mem [0:fbmc_pkg::NV_BYTES-1] = '{fbmc_pkg::FACTORY_STATUS,
    fbmc_pkg::FACTORY_BOOT_STATUS_WORD[7:0], fbmc_pkg::FACTORY_BOOT_STATUS_WORD[15:8],
    fbmc_pkg::FACTORY_BPC[7:0], fbmc_pkg::FACTORY_BPC[15:8]};
  logic mem_we, nv_we, nv_clear;
  logic [15:0] mem_waddr;
  logic [7:0] mem_wdata, nv_wdata;
  logic [2:0] nv_idx;

  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      flash_mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (nv_clear) begin
      for (int i = 0; i < fbmc_pkg::NV_BYTES; i++) begin
        nv_mem[i] <= fbmc_pkg::NV_ERASED;
      end
    end else if (nv_we) begin
      nv_mem[nv_idx] <= nv_wdata;
    end
  end

  // ----------------------------------------------------------------
  // block decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] blk_mask(input logic [15:0] a);
    if (a <= fbmc_pkg::SMALL_BLOCK_TOP) begin
      blk_mask = fbmc_pkg::SMALL_BLOCK_MASK;
    end else begin
      blk_mask = fbmc_pkg::LARGE_BLOCK_MASK;
    end
  endfunction

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  fbmc_pkg::fbmc_state_t state_reg, state_next;
  fbmc_pkg::fbmc_src_t src_reg, src_next;
  logic [2:0] op_reg, op_next;
  logic [15:0] addr_reg, addr_next, walk_reg, walk_next, last_reg, last_next;
  logic [7:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [15:0] cnt_reg, cnt_next, vpp_cnt_reg, vpp_cnt_next, wake_reg, wake_next;
  logic boot_reg, boot_next, flash_idle_request_reg, flash_idle_request_next, valid_reg, valid_next;
  logic pump_reg, pump_next, pdown_reg, pdown_next, vec_reg, vec_next;
  logic refused_reg, refused_next, error_reg, error_next;
  logic [15:0] rpc_reg, rpc_next, rpsw_reg, rpsw_next;
  logic wait_reg, wait_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] fcnt_reg, fcnt_next;
  logic [19:0] faddr_reg, faddr_next;
  logic fvalid_reg, fvalid_next, fwait_reg, fwait_next, erd_reg, erd_next;
  logic [7:0] fdata_reg, fdata_next;
  logic wr_take, strap, boot_at_reset, internal, start_ok;
  logic [7:0] old_byte;
  logic [2:0] cmd_op;

  assign strap = !program_fetch_strobe_n_n_s && ale_s && ext_sel_s;
  assign boot_at_reset = (nv_mem[fbmc_pkg::NV_STATUS] != fbmc_pkg::NV_ERASED) || strap;
  assign wr_take = AVS_WRITE && !wait_reg;
  assign cmd_op = AVS_WRITEDATA[2:0];
  assign old_byte = flash_mem[addr_reg];
  assign start_ok = valid_reg && (state_reg == fbmc_pkg::FBMC_IDLE);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    walk_next = walk_reg;
    last_next = last_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cnt_next = cnt_reg;
    boot_next = boot_reg;
    flash_idle_request_next = flash_idle_request_reg;
    refused_next = refused_reg;
    error_next = error_reg;
    mem_we = 1'b0;
    mem_waddr = walk_reg;
    mem_wdata = fbmc_pkg::FLASH_ERASED;
    nv_we = 1'b0;
    nv_clear = 1'b0;
    nv_idx = fbmc_pkg::NV_STATUS;
    nv_wdata = fbmc_pkg::STATUS_ERROR_VALUE;
    // register writes
    if (wr_take) begin
      if (AVS_ADDRESS == fbmc_pkg::REG_AUX) begin
        boot_next = AVS_WRITEDATA[fbmc_pkg::AUX_BOOT_BIT];
        flash_idle_request_next = AVS_WRITEDATA[fbmc_pkg::AUX_FLASH_IDLE_REQUEST_BIT];
      end else if (AVS_ADDRESS == fbmc_pkg::REG_ADDR) begin
        addr_next = AVS_WRITEDATA[15:0];
      end else if (AVS_ADDRESS == fbmc_pkg::REG_WDATA) begin
        wdata_next = AVS_WRITEDATA[7:0];
      end else if (AVS_ADDRESS == fbmc_pkg::REG_STATUS) begin
        if (AVS_WRITEDATA[fbmc_pkg::ST_REFUSED_BIT]) refused_next = 1'b0;
        if (AVS_WRITEDATA[fbmc_pkg::ST_ERROR_BIT]) error_next = 1'b0;
      end else if (AVS_ADDRESS == fbmc_pkg::REG_CMD) begin
        if (cmd_op == fbmc_pkg::OP_READ && state_reg == fbmc_pkg::FBMC_IDLE) begin
          rdata_next = old_byte;
        end else if (cmd_op == fbmc_pkg::OP_PROG || cmd_op == fbmc_pkg::OP_NV_PROG ||
                     cmd_op == fbmc_pkg::OP_NV_ERASE) begin
          if (start_ok) begin
            op_next = cmd_op;
            cnt_next = 16'(PROG_WAIT);
            state_next = fbmc_pkg::FBMC_PROG;
          end
        end else if (cmd_op == fbmc_pkg::OP_BLOCK_ERASE) begin
          if (start_ok) begin
            walk_next = addr_reg & ~blk_mask(addr_reg);
            last_next = addr_reg | blk_mask(addr_reg);
            state_next = fbmc_pkg::FBMC_ERASE;
          end
        end else if (cmd_op == fbmc_pkg::OP_CHIP_ERASE) begin
          if (start_ok) begin
            walk_next = fbmc_pkg::FLASH_FIRST;
            last_next = fbmc_pkg::FLASH_TOP;
            state_next = fbmc_pkg::FBMC_ERASE;
          end
        end
        if ((state_next == state_reg) && (cmd_op != fbmc_pkg::OP_READ)) begin
          refused_next = 1'b1;
        end else if (cmd_op == fbmc_pkg::OP_READ && state_reg != fbmc_pkg::FBMC_IDLE) begin
          refused_next = 1'b1;
        end
      end
    end
    // program and erase sequencing
    case (state_reg)
      fbmc_pkg::FBMC_PROG: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0001) begin
          state_next = fbmc_pkg::FBMC_IDLE;
          if (op_reg == fbmc_pkg::OP_NV_ERASE) begin
            nv_clear = 1'b1;
          end else if (op_reg == fbmc_pkg::OP_NV_PROG) begin
            nv_we = (addr_reg[2:0] < 3'(fbmc_pkg::NV_BYTES));
            nv_idx = addr_reg[2:0];
            nv_wdata = wdata_reg;
          end else begin
            mem_we = 1'b1;
            mem_waddr = addr_reg;
            mem_wdata = old_byte & wdata_reg;
            if ((wdata_reg & ~old_byte) != 8'h00) begin
              error_next = 1'b1;
              nv_we = 1'b1;
            end
          end
        end
      end
      fbmc_pkg::FBMC_ERASE: begin
        mem_we = 1'b1;
        walk_next = walk_reg + 16'h0001;
        if (walk_reg == last_reg) begin
          state_next = fbmc_pkg::FBMC_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // programming voltage, idle power and reset vector
  // ----------------------------------------------------------------
  always_comb begin
    pump_next = boot_next && vpp_tied_s;
    vpp_cnt_next = vpp_cnt_reg;
    valid_next = 1'b0;
    if (!boot_reg) begin
      vpp_cnt_next = 16'h0000;
    end else if (vpp_tied_s) begin
      if (vpp_cnt_reg != 16'(VPP_WAIT)) vpp_cnt_next = vpp_cnt_reg + 16'h0001;
      valid_next = (vpp_cnt_reg == 16'(VPP_WAIT));
    end else begin
      valid_next = vpp_ext_s;
    end
    pdown_next = CPU_IDLE && flash_idle_request_reg;
    wake_next = (wake_reg != 16'h0000) ? wake_reg - 16'h0001 : wake_reg;
    if (pdown_reg && !CPU_IDLE) wake_next = 16'(WAKE_WAIT);
    vec_next = vec_reg;
    rpc_next = rpc_reg;
    rpsw_next = rpsw_reg;
  end

  // ----------------------------------------------------------------
  // code fetch
  // ----------------------------------------------------------------
  always_comb begin
    src_next = src_reg;
    faddr_next = faddr_reg;
    fcnt_next = fcnt_reg;
    fvalid_next = 1'b0;
    fdata_next = fdata_reg;
    erd_next = erd_reg;
    internal = ext_sel_s && (FETCH_ADDR[19:16] == 4'h0);
    if (fcnt_reg != 2'h0) begin
      fcnt_next = fcnt_reg - 2'h1;
      if (fcnt_reg == 2'h1) begin
        fvalid_next = 1'b1;
        erd_next = 1'b0;
        if (src_reg == fbmc_pkg::FBMC_SRC_FLASH) fdata_next = flash_mem[faddr_reg[15:0]];
        else if (src_reg == fbmc_pkg::FBMC_SRC_ROM) fdata_next = BOOT_ROM_DATA;
        else fdata_next = ext_data_s;
      end
    end else if (FETCH_REQ && !fwait_reg) begin
      faddr_next = FETCH_ADDR;
      if (!internal) begin
        src_next = fbmc_pkg::FBMC_SRC_EXT;
        erd_next = 1'b1;
        fcnt_next = 2'(fbmc_pkg::EXT_FETCH_CYCLES);
      end else if (boot_reg && FETCH_ADDR[15:0] >= fbmc_pkg::BOOT_ROM_BASE) begin
        src_next = fbmc_pkg::FBMC_SRC_ROM;
        fcnt_next = 2'(fbmc_pkg::INT_FETCH_CYCLES);
      end else begin
        src_next = fbmc_pkg::FBMC_SRC_FLASH;
        fcnt_next = 2'(fbmc_pkg::INT_FETCH_CYCLES);
      end
    end
    fwait_next = (fcnt_next != 2'h0) || (state_next != fbmc_pkg::FBMC_IDLE) ||
                 pdown_next || (wake_next != 16'h0000);
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------------------------------
  always_comb begin
    wait_next = !((AVS_READ || AVS_WRITE) && wait_reg);
    rd_next = rd_reg;
    if (AVS_READ && wait_reg) begin
      rd_next = 32'h0000_0000;
      if (AVS_ADDRESS == fbmc_pkg::REG_AUX) begin
        rd_next[fbmc_pkg::AUX_BOOT_BIT] = boot_reg;
        rd_next[fbmc_pkg::AUX_VALID_BIT] = valid_reg;
      end else if (AVS_ADDRESS == fbmc_pkg::REG_ADDR) begin
        rd_next[15:0] = addr_reg;
      end else if (AVS_ADDRESS == fbmc_pkg::REG_WDATA) begin
        rd_next[7:0] = wdata_reg;
      end else if (AVS_ADDRESS == fbmc_pkg::REG_CMD) begin
        rd_next[2:0] = op_reg;
      end else if (AVS_ADDRESS == fbmc_pkg::REG_STATUS) begin
        rd_next[fbmc_pkg::ST_BUSY_BIT] = (state_reg != fbmc_pkg::FBMC_IDLE);
        rd_next[fbmc_pkg::ST_REFUSED_BIT] = refused_reg;
        rd_next[fbmc_pkg::ST_ERROR_BIT] = error_reg;
        rd_next[fbmc_pkg::ST_VECTOR_BIT] = vec_reg;
        rd_next[fbmc_pkg::ST_RDATA_LSB +: 8] = rdata_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= fbmc_pkg::FBMC_IDLE;
      src_reg <= fbmc_pkg::FBMC_SRC_FLASH;
      op_reg <= 3'h0;
      addr_reg <= 16'h0000;
      walk_reg <= 16'h0000;
      last_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      cnt_reg <= 16'h0000;
      vpp_cnt_reg <= 16'h0000;
      wake_reg <= 16'h0000;
      boot_reg <= boot_at_reset;
      flash_idle_request_reg <= 1'b0;
      valid_reg <= 1'b0;
      pump_reg <= 1'b0;
      pdown_reg <= 1'b0;
      vec_reg <= boot_at_reset;
      rpc_reg <= boot_at_reset ? {nv_mem[fbmc_pkg::NV_PC_HI], nv_mem[fbmc_pkg::NV_PC_LO]}
                               : fbmc_pkg::NORMAL_RESET_PC;
      rpsw_reg <= boot_at_reset ? {nv_mem[fbmc_pkg::NV_PSW_HI], nv_mem[fbmc_pkg::NV_PSW_LO]}
                                : fbmc_pkg::NORMAL_RESET_PSW;
      refused_reg <= 1'b0;
      error_reg <= 1'b0;
      wait_reg <= 1'b1;
      rd_reg <= 32'h0000_0000;
      fcnt_reg <= 2'h0;
      faddr_reg <= 20'h0_0000;
      fvalid_reg <= 1'b0;
      fwait_reg <= 1'b1;
      erd_reg <= 1'b0;
      fdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      src_reg <= src_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      walk_reg <= walk_next;
      last_reg <= last_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cnt_reg <= cnt_next;
      vpp_cnt_reg <= vpp_cnt_next;
      wake_reg <= wake_next;
      boot_reg <= boot_next;
      flash_idle_request_reg <= flash_idle_request_next;
      valid_reg <= valid_next;
      pump_reg <= pump_next;
      pdown_reg <= pdown_next;
      vec_reg <= vec_next;
      rpc_reg <= rpc_next;
      rpsw_reg <= rpsw_next;
      refused_reg <= refused_next;
      error_reg <= error_next;
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      fcnt_reg <= fcnt_next;
      faddr_reg <= faddr_next;
      fvalid_reg <= fvalid_next;
      fwait_reg <= fwait_next;
      erd_reg <= erd_next;
      fdata_reg <= fdata_next;
    end
  end

  assign AVS_READDATA = rd_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign FETCH_WAIT = fwait_reg;
  assign FETCH_VALID = fvalid_reg;
  assign FETCH_DATA = fdata_reg;
  assign BOOT_ROM_ADDR = faddr_reg[10:0];
  assign EXT_CODE_RD = erd_reg;
  assign EXT_CODE_ADDR = faddr_reg;
  assign BOOT_ROM_ENABLE = boot_reg;
  assign PROG_VOLTAGE_VALID = valid_reg;
  assign VPP_PUMP_ON = pump_reg;
  assign FLASH_POWER_DOWN = pdown_reg;
  assign BOOT_VECTOR_USED = vec_reg;
  assign RESET_PC = rpc_reg;
  assign RESET_PSW = rpsw_reg;
endmodule
`default_nettype wire

// *** dv/fbmc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbmc_assertions (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic FETCH_REQ,
  input wire logic FETCH_WAIT,
  input wire logic FETCH_VALID,
  input wire logic EXT_CODE_RD,
  input wire logic EXTERNAL_CODE_SELECT,
  input wire logic CPU_IDLE,
  input wire logic FLASH_POWER_DOWN,
  input wire logic BOOT_ROM_ENABLE,
  input wire logic PROG_VOLTAGE_VALID,
  input wire logic VPP_PUMP_ON,
  input wire logic BOOT_VECTOR_USED
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  pump_needs_boot_a: assert property (VPP_PUMP_ON |-> BOOT_ROM_ENABLE)
    else $error("pump on, boot rom off");
  valid_drops_a: assert property (!BOOT_ROM_ENABLE |=> !PROG_VOLTAGE_VALID)
    else $error("valid with boot rom off");
  valid_ready_a: assert property ($rose(VPP_PUMP_ON) |-> ##[1:8] PROG_VOLTAGE_VALID)
    else $error("valid late");
  fetch_answer_a: assert property (FETCH_REQ && !FETCH_WAIT |-> ##[2:4] FETCH_VALID)
    else $error("fetch unanswered");
  ext_fetch_a: assert property (FETCH_REQ && !FETCH_WAIT && !EXTERNAL_CODE_SELECT &&
    !$past(EXTERNAL_CODE_SELECT, 2) |=> EXT_CODE_RD) else $error("no external fetch");
  idle_power_a: assert property (FLASH_POWER_DOWN |-> $past(CPU_IDLE) && FETCH_WAIT)
    else $error("bad power down");
  wake_delay_a: assert property ($fell(CPU_IDLE) && FLASH_POWER_DOWN |-> FETCH_WAIT [*3])
    else $error("wake too short");
  boot_select_a: assert property ($fell(RST) |-> BOOT_ROM_ENABLE == BOOT_VECTOR_USED)
    else $error("boot enable mismatch");
endmodule
bind fbmc_top fbmc_assertions u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .FETCH_REQ(FETCH_REQ),
  .FETCH_WAIT(FETCH_WAIT), .FETCH_VALID(FETCH_VALID), .EXT_CODE_RD(EXT_CODE_RD),
  .EXTERNAL_CODE_SELECT(EXTERNAL_CODE_SELECT), .CPU_IDLE(CPU_IDLE),
  .FLASH_POWER_DOWN(FLASH_POWER_DOWN), .BOOT_ROM_ENABLE(BOOT_ROM_ENABLE),
  .PROG_VOLTAGE_VALID(PROG_VOLTAGE_VALID), .VPP_PUMP_ON(VPP_PUMP_ON),
  .BOOT_VECTOR_USED(BOOT_VECTOR_USED));
`default_nettype wire

// *** dv/fbmc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbmc_partner (
  input wire logic clk,
  input wire logic [10:0] rom_addr,
  output logic [7:0] rom_data,
  input wire logic ext_rd,
  input wire logic [19:0] ext_addr,
  output logic [7:0] ext_data
);
  logic [7:0] last_reg = 8'h00;
  assign rom_data = rom_addr[7:0] ^ 8'hA5;
  // released bus flips every cycle so a stale byte never passes
  assign ext_data = ext_rd ? (ext_addr[7:0] ^ 8'h3C) : ~last_reg;
  always @(posedge clk) last_reg <= ext_data;
endmodule
`default_nettype wire

// *** dv/test_flash_boot_map_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_boot_map_control;
  logic clk = '0, rst = '1, rd = '0, wr = '0, freq = '0, idle = '0, ea = '1, program_fetch_strobe_n_n = '1;
  logic ale = '1, vtied = '1, vext = '0;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q, seed = 32'h12;
  logic [19:0] faddr = '0, ext_a;
  logic [10:0] rom_a;
  logic [7:0] fdata, rom_d, ext_d, d0, d1, hi;
  logic [15:0] a0, a1, rpc, rpsw;
  logic wreq, fwait, fvalid, ext_rd, boot, valid, pump, pdown, bvu;
  int miscompares = 0, total_checks = 0;
  always #20 clk = !clk;
  fbmc_top #(.PROG_WAIT(4), .VPP_WAIT(3), .WAKE_WAIT(3)) DUT (.SYS_CLK(clk), .RST(rst),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .FETCH_REQ(freq), .FETCH_ADDR(faddr),
    .FETCH_WAIT(fwait), .FETCH_VALID(fvalid), .FETCH_DATA(fdata), .BOOT_ROM_ADDR(rom_a),
    .BOOT_ROM_DATA(rom_d), .EXT_CODE_RD(ext_rd), .EXT_CODE_ADDR(ext_a),
    .EXT_CODE_DATA(ext_d), .EXTERNAL_CODE_SELECT(ea), .PROGRAM_FETCH_STROBE_N(program_fetch_strobe_n_n),
    .ADDRESS_LATCH_STROBE(ale), .VPP_TIED_TO_VDD(vtied), .VPP_EXTERNAL_OK(vext),
    .CPU_IDLE(idle), .BOOT_ROM_ENABLE(boot), .PROG_VOLTAGE_VALID(valid),
    .VPP_PUMP_ON(pump), .FLASH_POWER_DOWN(pdown), .BOOT_VECTOR_USED(bvu),
    .RESET_PC(rpc), .RESET_PSW(rpsw));
  fbmc_partner u_far (.clk(clk), .rom_addr(rom_a), .rom_data(rom_d), .ext_rd(ext_rd),
    .ext_addr(ext_a), .ext_data(ext_d));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_b(input logic [19:0] a, input logic ext);
    return a[7:0] ^ (ext ? 8'h3C : 8'hA5);
  endfunction
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic reset_dut(input logic strap);
    rst <= 1'b1;
    program_fetch_strobe_n_n <= !strap;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    program_fetch_strobe_n_n <= 1'b1;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, fbmc_pkg::REG_ADDR, {16'h0000, a});
    bus(1'b1, fbmc_pkg::REG_WDATA, {24'h000000, d});
    bus(1'b1, fbmc_pkg::REG_CMD, {29'h0, op});
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      bus(1'b0, fbmc_pkg::REG_STATUS, '0);
    end
  endtask
  task automatic rdb(input logic [15:0] a, input logic [7:0] e, input string nm);
    cmd(fbmc_pkg::OP_READ, a, '0);
    chk(nm, q[15:8], e);
  endtask
  task automatic fetch(input logic [19:0] a, input logic [7:0] e, input string nm);
    faddr <= a;
    freq <= 1'b1;
    do begin
      @(posedge clk);
    end while (fwait !== 1'b0);
    freq <= 1'b0;
    do begin
      @(posedge clk);
    end while (fvalid !== 1'b1);
    chk(nm, fdata, e);
  endtask
  initial begin
    reset_dut(1'b0);
    chk("boot", boot, 1'b1);
    chk("vector used", bvu, 1'b1);
    chk("pc", rpc, fbmc_pkg::FACTORY_BPC);
    chk("psw", rpsw, fbmc_pkg::FACTORY_BOOT_STATUS_WORD);
    repeat (20) @(posedge clk);
    bus(1'b0, fbmc_pkg::REG_AUX, '0);
    chk("aux", q, 32'hC0);
    chk("pump", pump, 1'b1);
    cmd(fbmc_pkg::OP_CHIP_ERASE, '0, '0);
    a0 = 16'(rnd()) & 16'h1FFF;
    a1 = 16'(rnd()) | 16'hF800;
    d0 = 8'(rnd()) & 8'h7F;
    d1 = 8'(rnd()) & 8'hFE;
    cmd(fbmc_pkg::OP_PROG, a0, d0);
    cmd(fbmc_pkg::OP_PROG, a1, d1);
    rdb(a0, d0, "program");
    rdb(16'h4000, 8'hFF, "chip erase");
    fetch({4'h0, a0}, d0, "flash fetch");
    fetch({4'h0, a1}, exp_b({4'h0, a1}, 1'b0), "rom fetch");
    bus(1'b1, fbmc_pkg::REG_AUX, '0);
    fetch({4'h0, a1}, d1, "top fetch");
    chk("valid off", valid, 1'b0);
    cmd(fbmc_pkg::OP_PROG, a0, '0);
    chk("refused", q[1], 1'b1);
    rdb(a0, d0, "kept");
    bus(1'b1, fbmc_pkg::REG_AUX, 32'h80);
    repeat (20) @(posedge clk);
    cmd(fbmc_pkg::OP_BLOCK_ERASE, a0, '0);
    rdb(a0, 8'hFF, "block erase");
    rdb(a1, d1, "other block");
    cmd(fbmc_pkg::OP_NV_ERASE, '0, '0);
    cmd(fbmc_pkg::OP_PROG, a1, 8'hFF);
    chk("error", q[2], 1'b1);
    reset_dut(1'b0);
    chk("error boot", bvu, 1'b1);
    repeat (20) @(posedge clk);
    cmd(fbmc_pkg::OP_NV_ERASE, '0, '0);
    hi = 8'(rnd());
    cmd(fbmc_pkg::OP_NV_PROG, 16'h0004, hi);
    reset_dut(1'b0);
    chk("user boot", boot, 1'b0);
    chk("user pc", rpc, fbmc_pkg::NORMAL_RESET_PC);
    reset_dut(1'b1);
    chk("strap boot", boot, 1'b1);
    chk("strap pc", rpc, {hi, 8'h00});
    chk("strap psw", rpsw, 16'h0000);
    vtied <= 1'b0;
    vext <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ext pump", pump, 1'b0);
    chk("ext valid", valid, 1'b1);
    vtied <= 1'b1;
    ale <= 1'b0;
    reset_dut(1'b1);
    chk("no strap", boot, 1'b0);
    ale <= 1'b1;
    bus(1'b0, 5'h14, '0);
    chk("unmapped", q, '0);
    bus(1'b1, fbmc_pkg::REG_AUX, 32'hC0);
    idle <= 1'b1;
    repeat (4) @(posedge clk);
    chk("power down", pdown, 1'b1);
    idle <= 1'b0;
    fetch(20'h04000, 8'hFF, "wake fetch");
    fetch({4'h1, a0}, exp_b({4'h1, a0}, 1'b1), "high fetch");
    ea <= 1'b0;
    repeat (4) @(posedge clk);
    fetch({4'h0, a0}, exp_b({4'h0, a0}, 1'b1), "ext fetch");
    finish_test();
  end
  initial begin
    repeat (98000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
